// ==== shared/isx_pkg.sv ====
// Package of constants and types for the indexed stack instruction executer
// Function
// RQ1: Absolute-destination indexed move is two words, two cycles, 12-bit destination in word two.
// RQ2: Source address is stack pointer plus 7-bit offset; byte copied to absolute destination.
// RQ3: Program counter low and return top bytes as destination are unsupported.
// RQ4: Source on an indirect addressing register delivers zero data.
// RQ5: Relative-to-relative move: bit 7 set, second word 1111, don't-cares, 7-bit offset.
// RQ6: Both addresses are stack pointer plus their own offset, anywhere in memory.
// RQ7: Relative destination on indirect register performs no write, acts as no-operation.
// RQ8: Push literal writes literal at stack pointer, then decrements it, one cycle.
// RQ9: Subtract 6-bit literal from pointer 0 to 2, one cycle, no flags.
// RQ10: Select 11 subtracts from stack pointer then returns; two cycles, second idle.
// RQ11: Extended instructions decode only when extended set enable is high.
// RQ12: All pointer arithmetic wraps modulo 12-bit address width, flags untouched.
`default_nettype none
package isx_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 8;
	localparam int WORD_W = 16;
	localparam int OFS_W = 7;
	localparam int LIT6_W = 6;
	localparam int PTR_SEL_W = 2;
	localparam int NUM_PTR = 3;
	// Opcode patterns
	localparam logic [7:0] OP_MOVE_HI = 8'heb;
	localparam logic [7:0] OP_PUSH_HI = 8'hfa;
	localparam logic [7:0] OP_SUBP_HI = 8'he9;
	localparam logic [3:0] OP_SECOND = 4'hf;
	localparam logic [1:0] SEL_RETURN = 2'h3;
	localparam logic [1:0] SEL_STACK = 2'h2;
	localparam logic [1:0] SEL_PTR0 = 2'h0;
	localparam logic [1:0] SEL_PTR1 = 2'h1;
	// Field positions
	localparam int MODE_BIT = 7;
	localparam int SEL_LSB = 6;
	// Indirect register windows, five addresses per pointer
	localparam logic [11:0] IND2_LO = 12'hfdb;
	localparam logic [11:0] IND2_HI = 12'hfdf;
	localparam logic [11:0] IND1_LO = 12'hfe3;
	localparam logic [11:0] IND1_HI = 12'hfe7;
	localparam logic [11:0] IND0_LO = 12'hfeb;
	localparam logic [11:0] IND0_HI = 12'hfef;
	localparam logic [7:0] ZERO_DATA = 8'h00;
	localparam logic [11:0] RESET_PTR = 12'h000;
	localparam logic [11:0] ONE_ADDR = 12'h001;
	typedef enum logic [2:0] {
		ISX_IDLE,
		ISX_ABS_SECOND,
		ISX_REL_SECOND,
		ISX_RET_IDLE
	} isx_state_t;

	// Indirect register range: each bank occupies five consecutive addresses
	function automatic logic isx_is_indirect(input logic [11:0] a);
		return (a >= IND2_LO && a <= IND2_HI) || (a >= IND1_LO && a <= IND1_HI) ||
			(a >= IND0_LO && a <= IND0_HI);
	endfunction

	// Stack pointer plus offset, wrapped
	function automatic logic [11:0] isx_index(input logic [11:0] sp, input logic [6:0] ofs);
		return 12'(sp + {5'h00, ofs});
	endfunction
endpackage
`default_nettype wire

// ==== shared/isx_mem_if.sv ====
// Interface carrying the data memory port between decoder and memory stage
`timescale 1ns/10ps
`default_nettype none
interface isx_mem_if;
	logic rd_en;
	logic [11:0] rd_addr;
	logic [7:0] rd_data;
	logic wr_en;
	logic [11:0] wr_addr;
	logic [7:0] wr_data;
	modport ctrl (output rd_en, output rd_addr, input rd_data, output wr_en, output wr_addr,
		output wr_data);
	modport port (input rd_en, input rd_addr, output rd_data, input wr_en, input wr_addr,
		input wr_data);
endinterface
`default_nettype wire

// ==== verilog/isx_mem_port.sv ====
// Memory stage: registers the memory strobes and masks indirect source reads
`timescale 1ns/10ps
`default_nettype none
module isx_mem_port (
	input wire logic clock,
	input wire logic rst_n,
	isx_mem_if.port mif,
	input wire logic [7:0] mem_rd_data,
	output logic mem_rd_en,
	output logic [11:0] mem_rd_addr,
	output logic mem_wr_en,
	output logic [11:0] mem_wr_addr,
	output logic [7:0] mem_wr_data
);
	wire src_indirect;
	assign src_indirect = isx_pkg::isx_is_indirect(mif.rd_addr);
	// Indirect source is not read here; isx_exec substitutes the zero byte
	assign mif.rd_data = mem_rd_data; // Raw data; indirect zero byte substituted by src_zero_r in isx_exec
	// Registered memory strobes
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			mem_rd_en <= 1'b0;
			mem_rd_addr <= isx_pkg::RESET_PTR;
			mem_wr_en <= 1'b0;
			mem_wr_addr <= isx_pkg::RESET_PTR;
			mem_wr_data <= isx_pkg::ZERO_DATA;
		end else begin
			mem_rd_en <= mif.rd_en && !src_indirect; // [RQ4]
			mem_rd_addr <= mif.rd_addr;
			mem_wr_en <= mif.wr_en;
			mem_wr_addr <= mif.wr_addr;
			mem_wr_data <= mif.wr_data;
		end
	end
endmodule // isx_mem_port
`default_nettype wire

// ==== verilog/isx_exec.sv ====
// Decode and execution of indexed moves, literal push and pointer subtraction
`timescale 1ns/10ps
`default_nettype none
module isx_exec (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic extended_set_enable,
	input wire logic instr_valid,
	input wire logic [15:0] instr_word,
	input wire logic [7:0] mem_rd_data,
	input wire logic [11:0] ptr0_in,
	input wire logic [11:0] ptr1_in,
	input wire logic [11:0] stack_pointer_reg,
	output logic busy,
	output logic instr_taken,
	output logic mem_rd_en,
	output logic [11:0] mem_rd_addr,
	output logic mem_wr_en,
	output logic [11:0] mem_wr_addr,
	output logic [7:0] mem_wr_data,
	output logic ptr_wr_en,
	output logic [1:0] ptr_wr_sel,
	output logic [11:0] ptr_wr_data,
	output logic return_pop
);
	isx_mem_if mif ();
	isx_pkg::isx_state_t state_r, state_nxt;
	logic [11:0] src_addr_r;
	logic src_zero_r;
	logic busy_r;
	logic taken_r;
	logic pwe_r;
	logic [1:0] psel_r;
	logic [11:0] pdata_r;
	logic pop_r;
	logic [7:0] rd_hold_r;
	logic [11:0] wr_addr_c;
	logic wr_en_c;
	logic [7:0] wr_data_c;
	logic rd_en_c;
	logic [11:0] rd_addr_c;
	logic pwe_c;
	logic [1:0] psel_c;
	logic [11:0] pdata_c;

	// Field decode of the incoming word
	wire [7:0] op_hi = instr_word[15:8];
	wire [6:0] ofs = instr_word[6:0];
	wire [5:0] lit6 = instr_word[5:0];
	wire [1:0] sel = instr_word[7:6];
	wire [7:0] lit8 = instr_word[7:0];
	wire go = instr_valid && extended_set_enable; // [RQ11]
	wire idle = (state_r == isx_pkg::ISX_IDLE);
	wire dec_move = go && idle && op_hi == isx_pkg::OP_MOVE_HI;
	wire dec_abs = dec_move && !instr_word[isx_pkg::MODE_BIT]; // [RQ1]
	wire dec_rel = dec_move && instr_word[isx_pkg::MODE_BIT]; // [RQ5]
	wire dec_push = go && idle && op_hi == isx_pkg::OP_PUSH_HI; // [RQ8]
	wire dec_subp = go && idle && op_hi == isx_pkg::OP_SUBP_HI; // [RQ9]
	wire second_ok = instr_valid && instr_word[15:12] == isx_pkg::OP_SECOND;
	wire [11:0] src_c = isx_pkg::isx_index(stack_pointer_reg, ofs); // [RQ2] [RQ6]
	wire [11:0] rel_dst = isx_pkg::isx_index(stack_pointer_reg, ofs); // [RQ6]
	wire [11:0] abs_dst = instr_word[11:0]; // [RQ1] Full 000h to FFFh reach
	wire [7:0] src_live = mem_rd_en ? mif.rd_data : rd_hold_r; // Held if second word is late
	wire [7:0] src_data = src_zero_r ? isx_pkg::ZERO_DATA : src_live; // [RQ4]
	wire [11:0] sel_ptr = (sel == isx_pkg::SEL_PTR0) ? ptr0_in :
		(sel == isx_pkg::SEL_PTR1) ? ptr1_in : stack_pointer_reg;
	wire [11:0] sub_res = 12'(sel_ptr - {6'h00, lit6}); // [RQ12] [RQ9]
	wire [11:0] push_dec = 12'(stack_pointer_reg - isx_pkg::ONE_ADDR); // [RQ12]

	// Next-state and strobe selection
	always_comb begin
		state_nxt = state_r;
		rd_en_c = 1'b0;
		rd_addr_c = src_c;
		wr_en_c = 1'b0;
		wr_addr_c = isx_pkg::RESET_PTR;
		wr_data_c = isx_pkg::ZERO_DATA;
		pwe_c = 1'b0;
		psel_c = isx_pkg::SEL_STACK;
		pdata_c = sub_res;
		unique case (state_r)
			isx_pkg::ISX_IDLE: begin
				if (dec_abs) begin
					rd_en_c = 1'b1;
					state_nxt = isx_pkg::ISX_ABS_SECOND; // [RQ1]
				end else if (dec_rel) begin
					rd_en_c = 1'b1;
					state_nxt = isx_pkg::ISX_REL_SECOND; // [RQ5]
				end else if (dec_push) begin
					wr_en_c = 1'b1; // [RQ8] Literal at old pointer
					wr_addr_c = stack_pointer_reg;
					wr_data_c = lit8;
					pwe_c = 1'b1;
					pdata_c = push_dec;
				end else if (dec_subp) begin
					pwe_c = 1'b1; // [RQ9] No flags touched
					psel_c = (sel == isx_pkg::SEL_RETURN) ? isx_pkg::SEL_STACK : sel;
					if (sel == isx_pkg::SEL_RETURN) begin
						state_nxt = isx_pkg::ISX_RET_IDLE; // [RQ10]
					end
				end
			end
			isx_pkg::ISX_ABS_SECOND: begin
				if (second_ok) begin
					wr_en_c = 1'b1; // [RQ2] [RQ3] Special destinations not guarded
					wr_addr_c = abs_dst;
					wr_data_c = src_data;
					state_nxt = isx_pkg::ISX_IDLE;
				end
			end
			isx_pkg::ISX_REL_SECOND: begin
				if (second_ok) begin
					wr_en_c = !isx_pkg::isx_is_indirect(rel_dst); // [RQ7]
					wr_addr_c = rel_dst;
					wr_data_c = src_data;
					state_nxt = isx_pkg::ISX_IDLE;
				end
			end
			isx_pkg::ISX_RET_IDLE: begin
				state_nxt = isx_pkg::ISX_IDLE; // [RQ10] Second cycle idle
			end
			default: begin
				state_nxt = isx_pkg::ISX_IDLE;
			end
		endcase
	end

	assign mif.rd_en = rd_en_c;
	assign mif.rd_addr = rd_addr_c;
	assign mif.wr_en = wr_en_c;
	assign mif.wr_addr = wr_addr_c;
	assign mif.wr_data = wr_data_c;

	isx_mem_port u_mem (
		.clock(clock),
		.rst_n(rst_n),
		.mif(mif),
		.mem_rd_data(mem_rd_data),
		.mem_rd_en(mem_rd_en),
		.mem_rd_addr(mem_rd_addr),
		.mem_wr_en(mem_wr_en),
		.mem_wr_addr(mem_wr_addr),
		.mem_wr_data(mem_wr_data)
	);

	// State and source-zero capture
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= isx_pkg::ISX_IDLE;
			src_zero_r <= 1'b0;
			src_addr_r <= isx_pkg::RESET_PTR;
		end else begin
			state_r <= state_nxt;
			if (rd_en_c) begin
				src_zero_r <= isx_pkg::isx_is_indirect(src_c); // [RQ4]
				src_addr_r <= src_c;
			end
		end
	end

	// Source byte kept while the second word is late
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rd_hold_r <= isx_pkg::ZERO_DATA;
		end else if (mem_rd_en) begin
			rd_hold_r <= mif.rd_data; // [RQ2]
		end
	end

	// Registered pointer, return and status outputs
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pwe_r <= 1'b0;
			psel_r <= isx_pkg::SEL_STACK;
			pdata_r <= isx_pkg::RESET_PTR;
			pop_r <= 1'b0;
			busy_r <= 1'b0;
			taken_r <= 1'b0;
		end else begin
			pwe_r <= pwe_c;
			psel_r <= psel_c;
			pdata_r <= pdata_c;
			pop_r <= dec_subp && sel == isx_pkg::SEL_RETURN; // [RQ10]
			busy_r <= state_nxt != isx_pkg::ISX_IDLE;
			taken_r <= dec_abs || dec_rel || dec_push || dec_subp;
		end
	end

	assign busy = busy_r;
	assign instr_taken = taken_r;
	assign ptr_wr_en = pwe_r;
	assign ptr_wr_sel = psel_r;
	assign ptr_wr_data = pdata_r;
	assign return_pop = pop_r;

	// Push writes literal at old pointer and decrements by one
	push_order_a: assert property (@(posedge clock) disable iff (!rst_n) // [RQ8]
		dec_push |=> mem_wr_en && mem_wr_addr == $past(stack_pointer_reg) &&
		ptr_wr_data == 12'($past(stack_pointer_reg) - isx_pkg::ONE_ADDR) && ptr_wr_en)
		else $error("push literal ordering wrong");

	// Push finishes in one cycle with its own literal
	push_one_a: assert property (@(posedge clock) disable iff (!rst_n) // [RQ8]
		dec_push |=> mem_wr_data == $past(lit8) && ptr_wr_sel == isx_pkg::SEL_STACK && !busy)
		else $error("push literal data or length wrong");

	// Decrement below zero wraps to the top of the data space
	push_wrap_a: assert property (@(posedge clock) disable iff (!rst_n) // [RQ12]
		dec_push && stack_pointer_reg == isx_pkg::RESET_PTR |=>
		ptr_wr_data == {isx_pkg::ADDR_W{1'b1}})
		else $error("stack pointer wrap wrong");

	// Move and return steps
	sequence abs_seq;
		dec_abs ##1 second_ok;
	endsequence
	sequence rel_seq;
		dec_rel ##1 (second_ok && !isx_pkg::isx_is_indirect(rel_dst));
	endsequence
	sequence ret_seq;
		dec_subp && sel == isx_pkg::SEL_RETURN;
	endsequence

	// First word of either move holds the block for the second
	move_busy_a: assert property (@(posedge clock) disable iff (!rst_n) // [RQ1]
		dec_move |=> busy && instr_taken)
		else $error("move first word not held");

	// Absolute destination written from word two, then idle
	abs_move_a: assert property (@(posedge clock) disable iff (!rst_n) // [RQ1]
		abs_seq |=> mem_wr_en && mem_wr_addr == $past(instr_word[11:0]) && !busy)
		else $error("absolute move destination wrong");

	// Late second word: nothing written while waiting
	move_wait_a: assert property (@(posedge clock) disable iff (!rst_n) // [RQ1]
		state_r == isx_pkg::ISX_ABS_SECOND && !second_ok |=> !mem_wr_en && busy)
		else $error("move wrote before its second word");

	// Copied byte equals the byte read at the source
	abs_data_a: assert property (@(posedge clock) disable iff (!rst_n) // [RQ2]
		(dec_abs && !isx_pkg::isx_is_indirect(src_c)) ##1 (second_ok && mem_rd_en) |=>
		mem_wr_data == $past(mem_rd_data))
		else $error("absolute move data wrong");

	// Source read address is stack pointer plus offset
	src_index_a: assert property (@(posedge clock) disable iff (!rst_n) // [RQ2]
		dec_move |=> mem_rd_addr == 12'($past(stack_pointer_reg) + $past(instr_word[6:0])))
		else $error("indexed source address wrong");

	// Read address matches the captured move source
	src_hold_a: assert property (@(posedge clock) disable iff (!rst_n) // [RQ6]
		dec_move |=> mem_rd_addr == src_addr_r)
		else $error("source address capture wrong");

	// Indirect source never read from memory
	src_zero_a: assert property (@(posedge clock) disable iff (!rst_n) // [RQ4]
		dec_move && isx_pkg::isx_is_indirect(src_c) |=> !mem_rd_en)
		else $error("indirect source was read");

	// Indirect source hands over a zero byte
	zero_data_a: assert property (@(posedge clock) disable iff (!rst_n) // [RQ4]
		(dec_move && isx_pkg::isx_is_indirect(src_c)) ##1 second_ok |=>
		mem_wr_data == isx_pkg::ZERO_DATA)
		else $error("indirect source data not zero");

	// Relative destination is stack pointer plus second offset
	rel_move_a: assert property (@(posedge clock) disable iff (!rst_n) // [RQ6]
		rel_seq |=> mem_wr_en &&
		mem_wr_addr == 12'($past(stack_pointer_reg) + $past(instr_word[6:0])))
		else $error("relative move destination wrong");

	// Indirect relative destination turns the move into a no-operation
	rel_nop_a: assert property (@(posedge clock) disable iff (!rst_n) // [RQ7]
		state_r == isx_pkg::ISX_REL_SECOND && isx_pkg::isx_is_indirect(rel_dst) |=> !mem_wr_en)
		else $error("indirect destination written");

	// Subtract on pointers 0 to 2 in one cycle
	sub_ptr_a: assert property (@(posedge clock) disable iff (!rst_n) // [RQ9]
		dec_subp && sel != isx_pkg::SEL_RETURN |=> ptr_wr_en && ptr_wr_sel == $past(sel) &&
		ptr_wr_data == 12'($past(sel_ptr) - $past(lit6)) && !busy)
		else $error("pointer subtract wrong");

	// Subtract and return writes the stack pointer
	ret_sp_a: assert property (@(posedge clock) disable iff (!rst_n) // [RQ10]
		ret_seq |=> ptr_wr_en && ptr_wr_sel == isx_pkg::SEL_STACK &&
		ptr_wr_data == 12'($past(stack_pointer_reg) - $past(lit6)))
		else $error("subtract and return pointer wrong");

	// Pop in the first cycle only, busy through the idle one
	ret_two_a: assert property (@(posedge clock) disable iff (!rst_n) // [RQ10]
		ret_seq |=> return_pop && busy ##1 !busy && !return_pop)
		else $error("subtract and return timing wrong");

	// Nothing taken during the idle cycle after a return
	ret_gap_a: assert property (@(posedge clock) disable iff (!rst_n) // [RQ10]
		state_r == isx_pkg::ISX_RET_IDLE |=> !instr_taken && !ptr_wr_en && !mem_wr_en)
		else $error("instruction taken in return idle cycle");

	// Extended set off: no instruction taken
	gate_ext_a: assert property (@(posedge clock) disable iff (!rst_n) // [RQ11]
		!extended_set_enable && idle |=> !instr_taken)
		else $error("decoded while extended set off");

	// Extended set off: no memory or pointer side effects
	ext_quiet_a: assert property (@(posedge clock) disable iff (!rst_n) // [RQ11]
		!extended_set_enable && idle |=> !mem_wr_en && !ptr_wr_en && !busy)
		else $error("side effect while extended set off");
endmodule // isx_exec
`default_nettype wire

// ==== sim/isx_core_model.sv ====
// Behavioural model of data memory, pointer registers and return stack
`timescale 1ns/10ps
`default_nettype none
module isx_core_model (
	input wire logic clock,
	input wire logic mem_rd_en,
	input wire logic [11:0] mem_rd_addr,
	output logic [7:0] mem_rd_data,
	input wire logic mem_wr_en,
	input wire logic [11:0] mem_wr_addr,
	input wire logic [7:0] mem_wr_data,
	input wire logic ptr_wr_en,
	input wire logic [1:0] ptr_wr_sel,
	input wire logic [11:0] ptr_wr_data,
	input wire logic return_pop,
	output logic [11:0] ptr0,
	output logic [11:0] ptr1,
	output logic [11:0] sp
);
	logic [7:0] mem [0:4095];
	logic [7:0] noise_r = 8'h5a;
	int writes = 0;
	int pops = 0;
	// Unselected read bus shows a pattern that changes every cycle
	assign mem_rd_data = mem_rd_en ? mem[mem_rd_addr] : noise_r;
	// Memory, pointer and return stack updates
	always @(posedge clock) begin
		noise_r <= noise_r + 8'h3b;
		if (mem_wr_en) begin
			mem[mem_wr_addr] <= mem_wr_data;
			writes <= writes + 1;
		end
		if (ptr_wr_en) begin
			case (ptr_wr_sel)
				2'h0: ptr0 <= ptr_wr_data;
				2'h1: ptr1 <= ptr_wr_data;
				default: sp <= ptr_wr_data;
			endcase
		end
		if (return_pop)
			pops <= pops + 1;
	end
endmodule // isx_core_model
`default_nettype wire

// ==== sim/indexed_stack_instruction_exec_tb.sv ====
// Self-checking testbench for the indexed stack instruction executer
`timescale 1ns/10ps
`default_nettype none
module indexed_stack_instruction_exec_tb;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic extended_set_enable = 1'b1;
	logic instr_valid = 1'b0;
	logic [15:0] instr_word = 16'h0000;
	logic [7:0] mem_rd_data;
	logic [11:0] ptr0, ptr1, sp, mem_rd_addr, mem_wr_addr, ptr_wr_data;
	logic busy, instr_taken, mem_rd_en, mem_wr_en, ptr_wr_en, return_pop;
	logic [7:0] mem_wr_data;
	logic [1:0] ptr_wr_sel;
	int err_total = 0;
	int num_checks = 0;
	int w0;

	isx_exec dut_u (.clock(clock), .rst_n(rst_n), .extended_set_enable(extended_set_enable),
		.instr_valid(instr_valid), .instr_word(instr_word), .mem_rd_data(mem_rd_data),
		.ptr0_in(ptr0), .ptr1_in(ptr1), .stack_pointer_reg(sp), .busy(busy),
		.instr_taken(instr_taken), .mem_rd_en(mem_rd_en), .mem_rd_addr(mem_rd_addr),
		.mem_wr_en(mem_wr_en), .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
		.ptr_wr_en(ptr_wr_en), .ptr_wr_sel(ptr_wr_sel), .ptr_wr_data(ptr_wr_data),
		.return_pop(return_pop));
	isx_core_model m (.clock(clock), .mem_rd_en(mem_rd_en), .mem_rd_addr(mem_rd_addr),
		.mem_rd_data(mem_rd_data), .mem_wr_en(mem_wr_en), .mem_wr_addr(mem_wr_addr),
		.mem_wr_data(mem_wr_data), .ptr_wr_en(ptr_wr_en), .ptr_wr_sel(ptr_wr_sel),
		.ptr_wr_data(ptr_wr_data), .return_pop(return_pop), .ptr0(ptr0), .ptr1(ptr1), .sp(sp));

	// Clock generation
	always #5 clock = ~clock;

	// Compare and count
	task check(input logic [11:0] seen, input logic [11:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One instruction word per cycle, valid held across words
	task send(input logic [15:0] w);
		instr_valid <= 1'b1;
		instr_word <= w;
		@(posedge clock);
	endtask
	task idle(input int n);
		instr_valid <= 1'b0;
		repeat (n) @(posedge clock);
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Literal push, including wrap of the stack pointer below zero
	task t_push;
		m.sp <= 12'h000;
		idle(1);
		send(16'hfa08);
		idle(3);
		check({4'h0, m.mem[12'h000]}, 12'h008);
		check(m.sp, 12'hfff);
		send(16'hfa5c);
		idle(3);
		check({4'h0, m.mem[12'hfff]}, 12'h05c);
		check(m.sp, 12'hffe);
		$display("test push done");
	endtask
	// Subtract literal from each selectable pointer
	task t_subp;
		m.ptr0 <= 12'h010;
		m.ptr1 <= 12'h3ff;
		m.sp <= 12'h100;
		idle(1);
		for (int f = 0; f < 3; f++) begin
			send({8'he9, 2'(f), 6'h23});
			idle(3);
		end
		check(m.ptr0, 12'hfed);
		check(m.ptr1, 12'h3dc);
		check(m.sp, 12'h0dd);
		$display("test subtract done");
	endtask
	// Subtract from stack pointer and return
	task t_ret;
		m.sp <= 12'h3ff;
		w0 = m.pops;
		idle(1);
		send(16'he9e3);
		instr_valid <= 1'b0;
		@(negedge clock);
		check({11'h000, busy}, 12'h001);
		check({11'h000, instr_taken}, 12'h001);
		check({11'h000, return_pop}, 12'h001);
		@(negedge clock);
		check({10'h000, busy, return_pop}, 12'h000);
		idle(2);
		check(m.sp, 12'h3dc);
		check(12'(m.pops - w0), 12'h001);
		$display("test return done");
	endtask
	// Two-word move: sp, source offset, word two, preset source, destination, expected
	task move(input logic [11:0] s, input logic [7:0] w1, input logic [15:0] w2,
		input logic [11:0] src, input logic [11:0] dst, input logic [7:0] exp, input int gap);
		m.sp <= s;
		m.mem[src] <= 8'h33;
		m.mem[dst] <= 8'h11;
		idle(1);
		send({8'heb, w1});
		if (gap > 0)
			idle(gap);
		send(w2);
		idle(3);
		check({4'h0, m.mem[dst]}, {4'h0, exp});
	endtask
	task t_moves;
		move(12'h080, 8'h05, 16'hffff, 12'h085, 12'hfff, 8'h33, 0);
		move(12'h080, 8'h05, 16'hf200, 12'h085, 12'h200, 8'h33, 2);
		move(12'hfe0, 8'h0f, 16'hf123, 12'hfef, 12'h123, 8'h00, 0);
		move(12'h080, 8'h85, 16'hfa86, 12'h085, 12'h086, 8'h33, 0);
		move(12'hff0, 8'hff, 16'hf020, 12'h06f, 12'h010, 8'h33, 0);
		w0 = m.writes;
		move(12'hfe0, 8'h90, 16'hf00f, 12'hff0, 12'hfef, 8'h11, 0);
		check(12'(m.writes - w0), 12'h000);
		$display("test moves done");
	endtask
	// Extended set disabled: a push is ignored
	task t_disabled;
		m.sp <= 12'h200;
		extended_set_enable <= 1'b0;
		w0 = m.writes;
		idle(1);
		send(16'hfa77);
		idle(3);
		check(12'(m.writes - w0), 12'h000);
		check(m.sp, 12'h200);
		extended_set_enable <= 1'b1;
		idle(1);
		$display("test disabled done");
	endtask

	// Main sequence
	initial begin
		repeat (20) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		@(negedge clock);
		check({7'h00, busy, instr_taken, mem_wr_en, ptr_wr_en, return_pop}, 12'h000);
		t_push();
		t_subp();
		t_ret();
		t_moves();
		t_disabled();
		final_report();
	end
	// Watchdog
	initial begin
		repeat (5000) @(posedge clock);
		err_total++;
		final_report();
	end
endmodule // indexed_stack_instruction_exec_tb
`default_nettype wire
